// ### rtl/ocp_debounce.v
// Switch conditioner: two-flop synchroniser, stability filter, press pulse.
// Assumes raw active-high switch levels from the panel, asynchronous to ref_clk_i.
`timescale 1ns/1ns
`include "ocp_regs.vh"

module ocp_debounce (
    // Clock and reset.
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    // Raw switch and conditioned press pulse.
    input  wire        raw_i,
    output reg         press_o
);

    reg                 meta_q;
    reg                 sync_q;
    reg                 stable_q;
    reg [`OCP_DEB_W-1:0] cnt_q;

    // Synchroniser; the first flop feeds only the second.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= raw_i;
            sync_q <= meta_q;
        end
    end

    // Filter: accept a new level only after it held for the debounce time.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            stable_q <= 1'b0;
            cnt_q    <= {`OCP_DEB_W{1'b0}};
            press_o  <= 1'b0;
        end else begin
            press_o <= 1'b0;
            if (sync_q == stable_q) begin
                cnt_q <= {`OCP_DEB_W{1'b0}};
            end else if (cnt_q == `OCP_DEB_CYC - 1) begin
                cnt_q    <= {`OCP_DEB_W{1'b0}};
                stable_q <= sync_q;
                press_o  <= sync_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule // ocp_debounce

// ### rtl/ocp_panel.v
// Operator console panel core: display register, source selection, edit write-back,
// reset, manual interrupt, operator flags, memory show and store, and start.
// Assumes the processor samples the strobes below on ref_clk_i and drives status levels
// synchronously; the switch inputs are raw pins and pass through ocp_debounce.
`timescale 1ns/1ns
`include "ocp_regs.vh"

module ocp_panel (
    // Clock and reset.
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    // Raw panel switches.
    input  wire [15:0] entry_sw_i,
    input  wire        display_clear_switch_i,
    input  wire [4:0]  source_sw_i,
    input  wire [3:0]  code_sw_i,
    input  wire        code_clear_sw_i,
    input  wire        code_increment_switch_i,
    input  wire        memory_show_switch_i,
    input  wire        memory_store_sw_i,
    input  wire        step_run_sw_i,
    input  wire        start_sw_i,
    input  wire        int_sw_i,
    input  wire        reset_sw_i,
    input  wire [2:0]  flag_sw_i,
    // Processor status levels.
    input  wire [3:0]  key_bits_i,
    input  wire        alu_carry_flag_i,
    input  wire        alu_sign_flag_i,
    input  wire        alu_all_ones_flag_i,
    input  wire        alu_overflow_flag_i,
    input  wire [4:0]  shift_count_i,
    input  wire        alu_zero_flag_i,
    input  wire        supervisor_flag_i,
    input  wire        cpu_halted_i,
    input  wire [15:0] cpu_instr_i,
    input  wire [15:0] cpu_pc_i,
    input  wire        cpu_instr_is_halt_i,
    // Flag-condition query from the sequencer.
    input  wire [2:0]  cond_mask_i,
    input  wire        cond_all_i,
    // Memory read data.
    input  wire [15:0] mem_rdata_i,
    // Indicators.
    output reg  [15:0] display_o,
    output reg  [4:0]  source_led_o,
    output reg  [3:0]  code_led_o,
    output reg  [2:0]  flag_led_o,
    output reg         step_led_o,
    output reg         run_led_o,
    output reg         sign_led_o,
    // Processor control.
    output reg         instr_wr_o,
    output reg  [15:0] instr_wdata_o,
    output reg         pc_wr_o,
    output reg  [15:0] pc_wdata_o,
    output reg         start_o,
    output reg         start_first_exec_pc_o,
    output reg         int_req_o,
    output reg  [15:0] int_vector_o,
    output reg         cpu_halt_o,
    output reg         io_stop_o,
    output reg         sys_init_o,
    output reg         ovf_clear_o,
    output reg         cond_pass_o,
    // Memory access.
    output reg         mem_rd_o,
    output reg         mem_wr_o,
    output reg  [15:0] mem_addr_o,
    output reg  [15:0] mem_wdata_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Switch conditioning.

    localparam NSW = 37;
    wire [NSW-1:0] raw_w;
    wire [NSW-1:0] prs_w;
    assign raw_w = {entry_sw_i, display_clear_switch_i, source_sw_i, code_sw_i,
                    code_clear_sw_i, code_increment_switch_i, memory_show_switch_i,
                    memory_store_sw_i, step_run_sw_i, start_sw_i, int_sw_i, reset_sw_i,
                    flag_sw_i};

    genvar g;
    generate
        for (g = 0; g < NSW; g = g + 1) begin : g_sw
            ocp_debounce u_deb (
                .ref_clk_i (ref_clk_i),
                .sys_rst_i (sys_rst_i),
                .raw_i     (raw_w[g]),
                .press_o   (prs_w[g])
            );
        end
    endgenerate

    wire [15:0] p_entry  = prs_w[36:21];
    wire        p_clr    = prs_w[20];
    wire [4:0]  p_src    = prs_w[19:15];
    wire [3:0]  p_code   = prs_w[14:11];
    wire        p_cclr   = prs_w[10];
    wire        p_cinc   = prs_w[9];
    wire        p_show   = prs_w[8];
    wire        p_store  = prs_w[7];
    wire        p_steprn = prs_w[6];
    wire        p_start  = prs_w[5];
    wire        p_int    = prs_w[4];
    wire        p_reset  = prs_w[3];
    wire [2:0]  p_flag   = prs_w[2:0];

    ////////////////////////////////////////////////////////////////////////////////
    // Mode state.

    localparam MODE_STEP  = 2'd0;
    localparam MODE_ARMED = 2'd1;
    localparam MODE_RUN   = 2'd2;

    reg  [1:0]  mode_q;
    reg  [15:0] disp_q;
    reg  [4:0]  src_q;
    reg  [3:0]  code_q;
    reg  [2:0]  flag_q;
    reg  [15:0] blink_q;
    reg  [15:0] pc_q;
    wire [15:0] reg_rd_w;
    reg  [15:0] status_w;
    reg  [15:0] view_w;
    reg  [15:0] disp_d;
    reg         edit_w;

    wire stopped_w = (mode_q != MODE_RUN) || cpu_halted_i;

    // Status word assembled from processor signals; bit 0 reads zero.
    always @* begin
        status_w = `OCP_WORD_ZERO;
        status_w[`OCP_ST_KEY_HI:`OCP_ST_KEY_LO] = key_bits_i;
        status_w[`OCP_ST_CARRY] = alu_carry_flag_i;
        status_w[`OCP_ST_SIGN]  = alu_sign_flag_i;
        status_w[`OCP_ST_ONES]  = alu_all_ones_flag_i;
        status_w[`OCP_ST_OVF]   = alu_overflow_flag_i;
        status_w[`OCP_ST_SC_HI:`OCP_ST_SC_LO] = shift_count_i;
        status_w[`OCP_ST_ZERO]  = alu_zero_flag_i;
        status_w[`OCP_ST_SUPER] = supervisor_flag_i;
    end

    // Source view selected for loading the display when a source becomes active.
    always @* begin
        case (1'b1)
            src_q[`OCP_SRC_STATUS]: view_w = status_w;
            src_q[`OCP_SRC_INSTR]:  view_w = cpu_instr_i;
            src_q[`OCP_SRC_PC]:     view_w = cpu_pc_i;
            src_q[`OCP_SRC_REG]:    view_w = reg_rd_w;
            default:                view_w = disp_q;
        endcase
    end

    // Next display: clear wins over set; set only ORs bits in.
    always @* begin
        disp_d = disp_q;
        edit_w = 1'b0;
        if (p_clr) begin
            disp_d = `OCP_WORD_ZERO;
            edit_w = 1'b1;
        end else if (|(p_entry & ~disp_q)) begin
            disp_d = disp_q | p_entry;
            edit_w = 1'b1;
        end
    end

    // Register window for the code-selected view.
    ocp_regfile u_rf (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .code_i    (code_q),
        .wr_i      (edit_w && src_q[`OCP_SRC_REG]),
        .wdata_i   (disp_d),
        .instr_i   (cpu_instr_i),
        .rdata_o   (reg_rd_w)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Panel state and processor strobes.

    // One-cycle display refresh flag after a source or code change.
    reg refresh_q;

    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mode_q     <= MODE_STEP;
            disp_q     <= `OCP_WORD_ZERO;
            src_q      <= `OCP_SRC_RESET;
            code_q     <= `OCP_CODE_RESET;
            flag_q     <= 3'h0;
            blink_q    <= 16'h0000;
            pc_q       <= 16'h0000;
            refresh_q  <= 1'b0;
            instr_wr_o <= 1'b0;
            pc_wr_o    <= 1'b0;
            start_o    <= 1'b0;
            int_req_o  <= 1'b0;
            cpu_halt_o <= 1'b1;
            io_stop_o  <= 1'b1;
            sys_init_o <= 1'b1;
            ovf_clear_o <= 1'b1;
            mem_rd_o   <= 1'b0;
            mem_wr_o   <= 1'b0;
            instr_wdata_o <= 16'h0000;
            pc_wdata_o <= 16'h0000;
            mem_addr_o <= 16'h0000;
            mem_wdata_o <= 16'h0000;
            start_first_exec_pc_o <= 1'b0;
            int_vector_o <= `OCP_VECTOR_INT;
        end else begin
            instr_wr_o  <= 1'b0;
            pc_wr_o     <= 1'b0;
            start_o     <= 1'b0;
            int_req_o   <= 1'b0;
            cpu_halt_o  <= 1'b0;
            io_stop_o   <= 1'b0;
            sys_init_o  <= 1'b0;
            ovf_clear_o <= 1'b0;
            mem_rd_o    <= 1'b0;
            mem_wr_o    <= 1'b0;
            refresh_q   <= 1'b0;
            blink_q     <= blink_q + 1'b1;
            pc_q        <= cpu_pc_i;
            int_vector_o <= `OCP_VECTOR_INT;
            disp_q      <= disp_d;
            // Source selection, lowest switch first.
            if (|p_src) begin
                src_q     <= p_src & (~p_src + 5'h01);
                refresh_q <= 1'b1;
            end
            // Code entry, clear and increment.
            if (p_cclr) begin
                code_q <= `OCP_CODE_RESET;
            end else if (p_cinc) begin
                code_q <= code_q + 4'h1;
            end else begin
                code_q <= code_q | p_code;
            end
            if (p_cclr || p_cinc || |p_code) begin
                refresh_q <= 1'b1;
            end
            // Load display from the new view once the selection settles.
            if (refresh_q && stopped_w && !src_q[`OCP_SRC_MEM]) begin
                disp_q <= view_w;
            end
            // Edits copied to the instruction register or program counter.
            if (edit_w && src_q[`OCP_SRC_INSTR]) begin
                instr_wr_o    <= 1'b1;
                instr_wdata_o <= disp_d;
            end
            if (edit_w && src_q[`OCP_SRC_PC]) begin
                pc_wr_o    <= 1'b1;
                pc_wdata_o <= disp_d;
            end
            // Memory show and store, each advancing the program counter.
            if (src_q[`OCP_SRC_MEM] && (p_show || p_store)) begin
                mem_addr_o <= pc_q;
                mem_rd_o   <= p_show;
                mem_wr_o   <= p_store && !p_show;
                mem_wdata_o <= disp_q;
                pc_wr_o    <= 1'b1;
                pc_wdata_o <= pc_q + 16'h0001;
            end
            if (mem_rd_o) begin
                disp_q <= mem_rdata_i;
            end
            // Operator flags toggle on each press.
            flag_q <= flag_q ^ p_flag;
            // Mode sequencing.
            case (mode_q)
                MODE_STEP: begin
                    if (p_steprn) begin
                        mode_q <= MODE_ARMED;
                    end else if (p_start) begin
                        start_o <= 1'b1;
                        start_first_exec_pc_o <= cpu_instr_is_halt_i;
                    end
                end
                MODE_ARMED: begin
                    if (p_steprn) begin
                        mode_q <= MODE_STEP;
                    end else if (p_start) begin
                        mode_q  <= MODE_RUN;
                        start_o <= 1'b1;
                        start_first_exec_pc_o <= cpu_instr_is_halt_i;
                    end
                end
                MODE_RUN: begin
                    if (p_steprn) begin
                        mode_q     <= MODE_STEP;
                        cpu_halt_o <= 1'b1;
                    end else if (p_int && !cpu_halted_i) begin
                        int_req_o <= 1'b1;
                    end
                end
                default: mode_q <= MODE_STEP;
            endcase
            // Reset switch overrides the mode sequencing and its start and interrupt strobes.
            if (p_reset) begin
                mode_q      <= MODE_STEP;
                cpu_halt_o  <= 1'b1;
                io_stop_o   <= 1'b1;
                sys_init_o  <= 1'b1;
                ovf_clear_o <= 1'b1;
                int_req_o   <= 1'b0;
                start_o     <= 1'b0;
            end
        end
    end

    // Indicator and condition outputs, registered.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            display_o    <= `OCP_WORD_ZERO;
            source_led_o <= `OCP_SRC_RESET;
            code_led_o   <= `OCP_CODE_RESET;
            flag_led_o   <= 3'h0;
            step_led_o   <= 1'b1;
            run_led_o    <= 1'b0;
            sign_led_o   <= 1'b0;
            cond_pass_o  <= 1'b0;
        end else begin
            display_o    <= disp_q;
            sign_led_o   <= disp_q[`OCP_SIGN_BIT];
            source_led_o <= src_q;
            code_led_o   <= code_q;
            flag_led_o   <= flag_q;
            step_led_o   <= (mode_q == MODE_STEP);
            run_led_o    <= (mode_q == MODE_RUN && !cpu_halted_i) ||
                            (mode_q != MODE_STEP && blink_q[15]);
            cond_pass_o  <= cond_all_i ? ((flag_q & cond_mask_i) == cond_mask_i)
                                       : |(flag_q & cond_mask_i);
        end
    end

endmodule // ocp_panel

// ### rtl/ocp_regfile.v
// Panel-visible register window: eight general and five microprogram registers, plus three fixed views.
// Assumes writes come from the panel core on the same clock.
`timescale 1ns/1ns
`include "ocp_regs.vh"

module ocp_regfile (
    // Clock and reset.
    input  wire        ref_clk_i,
    input  wire        sys_rst_i,
    // Access by code.
    input  wire [3:0]  code_i,
    input  wire        wr_i,
    input  wire [15:0] wdata_i,
    input  wire [15:0] instr_i,
    output reg  [15:0] rdata_o
);

    reg [15:0] regs_q [0:15];
    integer    k;

    // Codes 1000, 1011 and 1100 are fixed views and refuse writes.
    always @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            for (k = 0; k < 16; k = k + 1) begin
                regs_q[k] <= `OCP_WORD_ZERO;
            end
        end else if (wr_i && code_i != `OCP_CODE_INSTR && code_i != `OCP_CODE_ZEROS
                     && code_i != `OCP_CODE_ONES) begin
            regs_q[code_i] <= wdata_i;
        end
    end

    // Read path; general registers below eight, microprogram above.
    always @* begin
        case (code_i)
            `OCP_CODE_INSTR: rdata_o = instr_i;
            `OCP_CODE_ZEROS: rdata_o = `OCP_WORD_ZERO;
            `OCP_CODE_ONES:  rdata_o = `OCP_WORD_ONES;
            default:         rdata_o = regs_q[code_i];
        endcase
    end

endmodule // ocp_regfile

// ### rtl/ocp_regs.vh
// Constants of the operator console panel: display sources, status field positions,
// register codes and debounce timing.
// Assumes inclusion by bare name from the panel modules; definitions only.
//
// How it works
// - Sixteen-bit display register drives sixteen indicators.
// - Display clear switch zeroes whole display register.
// - Entry switches only set bits, never clear.
// - Display bit fifteen is the sign.
// - Five source selects are one-hot, latest wins.
// - Status bits fifteen to twelve show key bits.
// - Status bits eleven to eight show ALU flags.
// - Status bits seven to three show shift count.
// - Status bit two zero, one supervisor, zero unused.
// - Instruction source shows instruction register when stopped.
// - Display edits copy into instruction register.
// - Program counter source shows and takes edits.
// - Start address depends on halt in instruction register.
// - Four-bit code picks general or microprogram register.
// - Chosen register shown at once, edits written back.
// - Code 1000 reads instruction, 1011/1100 constant, unwritable.
// - Code clear zeroes code, increment adds one.
// - Manual interrupt only while running, vectors to zero.
// - Reset halts, steps, stops I/O, clears overflow.
// - Three flag switches toggle, indicators follow flags.
// - Flag-conditioned jumps act only when flag holds.
// - Memory show reads word, store writes entry data.
// - Program counter advances after memory show or store.
`ifndef OCP_REGS_VH
`define OCP_REGS_VH

// One-hot source select positions.
`define OCP_SRC_MEM     0
`define OCP_SRC_STATUS  1
`define OCP_SRC_INSTR   2
`define OCP_SRC_PC      3
`define OCP_SRC_REG     4
`define OCP_SRC_RESET   5'h10

// Status view field positions.
`define OCP_ST_KEY_HI   15
`define OCP_ST_KEY_LO   12
`define OCP_ST_CARRY    11
`define OCP_ST_SIGN     10
`define OCP_ST_ONES     9
`define OCP_ST_OVF      8
`define OCP_ST_SC_HI    7
`define OCP_ST_SC_LO    3
`define OCP_ST_ZERO     2
`define OCP_ST_SUPER    1
`define OCP_SIGN_BIT    15

// Register selection codes.
`define OCP_CODE_INSTR  4'h8
`define OCP_CODE_ZEROS  4'hb
`define OCP_CODE_ONES   4'hc
`define OCP_CODE_RESET  4'h0
`define OCP_WORD_ZERO   16'h0000
`define OCP_WORD_ONES   16'hffff
`define OCP_VECTOR_INT  16'h0000

// Debounce: stable time in microseconds, cycles at 100 MHz.
`define OCP_DEB_US      5
`define OCP_CLK_MHZ     100
`define OCP_DEB_CYC     (`OCP_DEB_US * `OCP_CLK_MHZ)
`define OCP_DEB_W       10

`endif

// ### sim/ocp_cpu_model.sv
// Processor-side model: instruction register, program counter and a small memory.
// Assumes one-cycle write strobes from the panel on ref_clk_i.
`timescale 1ns/1ns
module ocp_cpu_model (
    input  wire         ref_clk_i,
    input  wire         instr_wr_i,
    input  wire  [15:0] instr_wdata_i,
    input  wire         pc_wr_i,
    input  wire  [15:0] pc_wdata_i,
    input  wire         mem_wr_i,
    input  wire  [15:0] mem_addr_i,
    input  wire  [15:0] mem_wdata_i,
    output logic [15:0] cpu_instr_o,
    output logic [15:0] cpu_pc_o,
    output wire  [15:0] mem_rdata_o
);
    logic [15:0] mem_q [0:63];
    // Known start contents so every view has a distinct expected word.
    initial begin
        cpu_instr_o = 16'h1234;
        cpu_pc_o = 16'h0010;
        for (int i = 0; i < 64; i++) mem_q[i] = 16'(i) ^ 16'h5a5a;
    end
    // Registers and memory take the panel's writes.
    always @(posedge ref_clk_i) begin
        if (instr_wr_i) cpu_instr_o <= instr_wdata_i;
        if (pc_wr_i) cpu_pc_o <= pc_wdata_i;
        if (mem_wr_i) mem_q[mem_addr_i[5:0]] <= mem_wdata_i;
    end
    // Memory is read without delay at the current address.
    assign mem_rdata_o = mem_q[mem_addr_i[5:0]];
endmodule // ocp_cpu_model

// ### sim/ocp_panel_properties.sv
// Checker of the panel core ports: views, edit strobes, memory steps, flags, reset.
// Assumes the single clock ref_clk_i and the synchronous reset sys_rst_i.
`timescale 1ns/1ns
module ocp_panel_properties (
    input wire        ref_clk_i,
    input wire        sys_rst_i,
    input wire [2:0]  cond_mask_i,
    input wire        cond_all_i,
    input wire [15:0] mem_rdata_i,
    input wire [15:0] display_o,
    input wire [4:0]  source_led_o,
    input wire [2:0]  flag_led_o,
    input wire        step_led_o,
    input wire        run_led_o,
    input wire        sign_led_o,
    input wire        instr_wr_o,
    input wire [15:0] instr_wdata_o,
    input wire        pc_wr_o,
    input wire [15:0] pc_wdata_o,
    input wire        int_req_o,
    input wire [15:0] int_vector_o,
    input wire        cpu_halt_o,
    input wire        ovf_clear_o,
    input wire        cond_pass_o,
    input wire        mem_rd_o,
    input wire        mem_wr_o,
    input wire [15:0] mem_addr_o,
    input wire [15:0] mem_wdata_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    // Memory access steps: the counter moves on, then the shown word lands.
    sequence s_pc_bumped;
        pc_wr_o && pc_wdata_o == mem_addr_o + 16'h0001;
    endsequence
    sequence s_show_lands;
        ##[0:2] display_o == mem_rdata_i;
    endsequence
    a_reset_levels: assert property (disable iff (1'b0)
        sys_rst_i |=> display_o == 16'h0000 && step_led_o && !run_led_o && cpu_halt_o && ovf_clear_o)
        else $error("reset levels wrong");
    a_source_onehot: assert property ($onehot(source_led_o))
        else $error("source indicators not one-hot");
    a_sign_follows: assert property ($stable(display_o) |-> sign_led_o == display_o[15])
        else $error("sign indicator differs from display bit");
    a_instr_edit: assert property (
        instr_wr_o |-> source_led_o[2] ##1 display_o == $past(instr_wdata_o))
        else $error("instruction write does not match display");
    a_pc_edit: assert property (
        pc_wr_o && !mem_rd_o && !mem_wr_o |-> source_led_o[3] ##1 display_o == $past(pc_wdata_o))
        else $error("counter write does not match display");
    a_mem_show: assert property (mem_rd_o |-> s_pc_bumped ##1 s_show_lands)
        else $error("memory show step wrong");
    a_mem_store: assert property (mem_wr_o |-> s_pc_bumped ##0 mem_wdata_o == display_o)
        else $error("memory store step wrong");
    a_int_vector: assert property (
        int_req_o |-> int_vector_o == 16'h0000 && run_led_o && !step_led_o)
        else $error("interrupt outside run or bad vector");
    a_flag_toggle: assert property ($changed(flag_led_o) |-> $onehot(flag_led_o ^ $past(flag_led_o)))
        else $error("more than one flag changed");
    a_cond_pass: assert property (cond_pass_o == ($past(cond_all_i) ? ((flag_led_o & $past(cond_mask_i))
        == $past(cond_mask_i)) : |(flag_led_o & $past(cond_mask_i)))) else $error("flag condition result wrong");
endmodule // ocp_panel_properties

bind ocp_panel ocp_panel_properties chk (.*);

// ### sim/testbench.sv
// Self-checking bench of the panel core, driving raw switches one press at a time.
// Assumes the design's fixed 500-cycle switch filter.
`timescale 1ns/1ns
module testbench;
    logic        ref_clk_i = 1'b0, sys_rst_i = 1'b1;
    logic [36:0] sw = '0;
    logic [15:0] st = 16'h0000;
    logic        cpu_instr_is_halt_i = 1'b0, cpu_halted_i = 1'b0;
    logic [2:0]  cond_mask_i = 3'h5;
    logic        cond_all_i = 1'b1;
    int          err_count = 0, comparisons = 0, n_int = 0, n_halt = 0;
    // Switch and status bundles fan out to the named inputs.
    wire [15:0] entry_sw_i = sw[15:0];
    wire display_clear_switch_i = sw[16], code_clear_sw_i = sw[26], code_increment_switch_i = sw[27];
    wire [4:0] source_sw_i = sw[21:17];
    wire [3:0] code_sw_i = sw[25:22];
    wire memory_show_switch_i = sw[28], memory_store_sw_i = sw[29], step_run_sw_i = sw[30], start_sw_i = sw[31];
    wire int_sw_i = sw[32], reset_sw_i = sw[33];
    wire [2:0] flag_sw_i = sw[36:34];
    wire [3:0] key_bits_i = st[15:12];
    wire alu_carry_flag_i = st[11], alu_sign_flag_i = st[10], alu_all_ones_flag_i = st[9];
    wire alu_overflow_flag_i = st[8], alu_zero_flag_i = st[2], supervisor_flag_i = st[1];
    wire [4:0] shift_count_i = st[7:3];
    wire [15:0] cpu_instr_i, cpu_pc_i, mem_rdata_i, display_o, instr_wdata_o, pc_wdata_o;
    wire [15:0] int_vector_o, mem_addr_o, mem_wdata_o;
    wire [4:0] source_led_o;
    wire [3:0] code_led_o;
    wire [2:0] flag_led_o;
    wire step_led_o, run_led_o, sign_led_o, instr_wr_o, pc_wr_o, start_o, start_first_exec_pc_o;
    wire int_req_o, cpu_halt_o, io_stop_o, sys_init_o, ovf_clear_o, cond_pass_o, mem_rd_o, mem_wr_o;
    ocp_panel dut (.*);
    ocp_cpu_model cpu (.ref_clk_i(ref_clk_i), .instr_wr_i(instr_wr_o), .instr_wdata_i(instr_wdata_o),
        .pc_wr_i(pc_wr_o), .pc_wdata_i(pc_wdata_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .cpu_instr_o(cpu_instr_i), .cpu_pc_o(cpu_pc_i), .mem_rdata_o(mem_rdata_i));
    ////////////////////////////////////////
    // Clock, pulse counters and watchdog.
    initial begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (int_req_o === 1'b1) n_int <= n_int + 1;
        if (cpu_halt_o === 1'b1 && io_stop_o === 1'b1 && sys_init_o === 1'b1 && ovf_clear_o === 1'b1) n_halt <= n_halt + 1;
    end
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        err_count++;
        wrap_up();
    end
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One press: held 520 cycles, past the filter, then released for 530.
    task automatic press(input int id);
        @(negedge ref_clk_i) sw[id] = 1'b1;
        repeat (520) @(negedge ref_clk_i);
        sw[id] = 1'b0;
        repeat (530) @(negedge ref_clk_i);
    endtask
    task automatic wrap_up;
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    task automatic t_reset;
        check("display", display_o, 16'h0000);
        check("source", source_led_o, 5'h10);
        check("code", code_led_o, 4'h0);
        check("flags", flag_led_o, 3'h0);
        check("step", step_led_o, 1'b1);
        check("run", run_led_o, 1'b0);
    endtask
    task automatic t_entry;
        press(15);
        check("display", display_o, 16'h8000);
        check("sign", sign_led_o, 1'b1);
        press(0);
        press(0);
        check("display", display_o, 16'h8001);
        press(16);
        check("display", display_o, 16'h0000);
        press(3);
        check("display", display_o, 16'h0008);
    endtask
    task automatic t_code;
        press(25);
        check("code", code_led_o, 4'h8);
        check("display", display_o, 16'h1234);
        repeat (3) press(27);
        check("code", code_led_o, 4'hb);
        check("display", display_o, 16'h0000);
        press(0);
        press(27);
        check("display", display_o, 16'hffff);
        press(26);
        check("code", code_led_o, 4'h0);
        check("display", display_o, 16'h0008);
        press(25);
        press(23);
        press(22);
        check("display", display_o, 16'h0000);
    endtask
    task automatic t_status;
        st = 16'habb7;
        press(18);
        check("source", source_led_o, 5'h02);
        check("display", display_o, 16'habb6);
    endtask
    task automatic t_memory;
        press(20);
        check("display", display_o, 16'h0010);
        press(16);
        press(2);
        check("pc", cpu_pc_i, 16'h0004);
        press(17);
        press(16);
        press(0);
        press(29);
        check("stored", cpu.mem_q[4], 16'h0001);
        check("pc", cpu_pc_i, 16'h0005);
        press(28);
        check("display", display_o, 16'h5a5f);
        check("pc", cpu_pc_i, 16'h0006);
    endtask
    task automatic t_instr;
        press(19);
        check("display", display_o, 16'h1234);
        press(16);
        press(5);
        check("instr", cpu_instr_i, 16'h0020);
    endtask
    task automatic t_flags;
        press(34);
        press(36);
        check("flags", flag_led_o, 3'h5);
        check("cond all", cond_pass_o, 1'b1);
        press(34);
        check("flags", flag_led_o, 3'h4);
        check("cond all", cond_pass_o, 1'b0);
        cond_all_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check("cond any", cond_pass_o, 1'b1);
    endtask
    task automatic t_run;
        int h;
        press(32);
        check("int idle", 16'(n_int), 16'h0000);
        press(30);
        cpu_instr_is_halt_i = 1'b1;
        press(31);
        check("first exec", start_first_exec_pc_o, 1'b1);
        check("run", run_led_o, 1'b1);
        press(32);
        check("int taken", 16'(n_int), 16'h0001);
        cpu_halted_i = 1'b1;
        press(32);
        check("int halted", 16'(n_int), 16'h0001);
        h = n_halt;
        press(33);
        check("halt pulses", 16'(n_halt - h), 16'h0001);
        check("step", step_led_o, 1'b1);
        check("run", run_led_o, 1'b0);
    endtask
    // Main sequence: reset, then each scenario in turn.
    initial begin
        repeat (12) @(negedge ref_clk_i);
        sys_rst_i = 1'b0;
        t_reset();
        t_entry();
        t_code();
        t_status();
        t_memory();
        t_instr();
        t_flags();
        t_run();
        wrap_up();
    end
endmodule // testbench
